// *** rtl/sdr_top.sv ***
// serial diagnostic responder: uart, sticky anomaly bytes, warning counters, text report
// assumes a classic wishbone master and synchronous switch and rx inputs
//
// Functional notes
// R1: link_role_switch off enables diagnostic ascii link
// R2: baud switches pick rate, both off 9600
// R3: baud switches latched once after reset only
// R4: frames are 8 data, no parity, 1 stop
// R5: query character starts full status report
// R6: runs beside the multidrop link, no blocking
// R7: four warning counters, cleared only by reset
// R8: anode range, emission fail, rf_frequency_lock_warning raise warnings
// R9: one sticky anomaly byte per category, reported
// R10: anode byte bit7 low, bit6 high
// R11: control card bits 5..1, others zero
// R12: calibration bits 7..4 dac limits, others zero
// R13: emission byte integrator, cold, warm start bits
// R14: temperature in celsius, above 75 flagged
// R15: anode readback is voltage over 100
// R16: setpoint readback is half the setpoint
// R17: measured rf frequency included in report
// R18: switches, remote inputs, three port statistics reported
// R19: every report line ends with cr lf
// R20: anomaly bits stay set until reset
`include "sdr_map.svh"
module sdr_top
  import sdr_pkg::*;
#(
  parameter int unsigned BIT_CYC_00 = `SDR_CLK_HZ / `SDR_BAUD_00,
  parameter int unsigned BIT_CYC_01 = `SDR_CLK_HZ / `SDR_BAUD_01,
  parameter int unsigned BIT_CYC_10 = `SDR_CLK_HZ / `SDR_BAUD_10,
  parameter int unsigned BIT_CYC_11 = `SDR_CLK_HZ / `SDR_BAUD_11,
  parameter int unsigned CNT_W      = 16
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        link_role_switch,
  input  wire logic        baud_select_low_switch,
  input  wire logic        baud_select_high_switch,
  input  wire logic [7:0]  config_switches,
  input  wire logic [1:0]  remote_inputs,
  input  wire logic        diag_rx,
  output logic             diag_tx,
  output logic             diag_active
);
  initial begin
    if (BIT_CYC_00 < 16 || BIT_CYC_00 > 65535 || BIT_CYC_01 < 16 || BIT_CYC_01 > 65535 ||
        BIT_CYC_10 < 16 || BIT_CYC_10 > 65535 || BIT_CYC_11 < 16 || BIT_CYC_11 > 65535 ||
        CNT_W < 8 || CNT_W > 32)
      $error("sdr_top: bit period or counter width out of range");
  end

  // ---------------- baud latch: switches only read once after reset
  logic        baud_taken;
  logic [1:0]  baud_sel;
  logic [15:0] bit_cyc;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_taken <= 1'b0;
      baud_sel   <= 2'b00;
    end else if (!baud_taken) begin
      baud_taken <= 1'b1; // R3
      baud_sel   <= {baud_select_high_switch, baud_select_low_switch}; // R3
    end
  end
  assign bit_cyc = (baud_sel == 2'b00) ? 16'(BIT_CYC_00) : // R2
                   (baud_sel == 2'b01) ? 16'(BIT_CYC_01) :
                   (baud_sel == 2'b10) ? 16'(BIT_CYC_10) : 16'(BIT_CYC_11);
  wire diag_en = baud_taken && !link_role_switch; // R1

  // ---------------- receiver, 8n1; shares nothing with the multidrop link
  logic        rx_busy;
  logic [15:0] rx_cnt;
  logic [3:0]  rx_bit;
  logic [7:0]  rx_sh;
  logic        rx_done;
  logic        rx_ferr;
  wire rx_tick  = rx_busy && rx_cnt == 16'd0;
  wire rx_start = diag_en && !rx_busy && !diag_rx;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy <= 1'b0;
      rx_cnt  <= 16'd0;
      rx_bit  <= 4'd0;
      rx_sh   <= 8'h00;
      rx_done <= 1'b0;
      rx_ferr <= 1'b0;
    end else begin
      rx_done <= rx_tick && rx_bit == 4'd9 && diag_rx; // R4
      rx_ferr <= rx_tick && rx_bit == 4'd9 && !diag_rx; // R4
      if (rx_start) begin
        rx_busy <= 1'b1; // R6
        rx_cnt  <= {1'b0, bit_cyc[15:1]};
        rx_bit  <= 4'd0;
      end else if (rx_tick) begin
        rx_cnt <= bit_cyc - 16'd1;
        rx_bit <= rx_bit + 4'd1;
        if (rx_bit >= 4'd1 && rx_bit <= 4'd8) rx_sh <= {diag_rx, rx_sh[7:1]}; // R4
        if ((rx_bit == 4'd0 && diag_rx) || rx_bit == 4'd9) rx_busy <= 1'b0;
      end else if (rx_busy) begin
        rx_cnt <= rx_cnt - 16'd1;
      end
    end
  end
  wire query = rx_done && rx_sh == `SDR_QUERY_CHAR; // R5

  // ---------------- software registers: readings mirrored from the analog chain
  logic [15:0] temp_c, setpoint, anode_v, emis_mv, rf_khz;
  logic [31:0] port1, port2;
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr  = wb_req && wb_we_i;
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] evt_w = (wb_wr && wb_adr_i == `SDR_OFF_EVENT) ? (wb_dat_i & wmask) : 32'h0;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_c   <= 16'h0000;
      setpoint <= 16'h0000;
      anode_v  <= 16'h0000;
      emis_mv  <= 16'h0000;
      rf_khz   <= 16'h0000;
      port1    <= `SDR_RESET_WORD;
      port2    <= `SDR_RESET_WORD;
    end else if (wb_wr) begin
      case (wb_adr_i)
        `SDR_OFF_TEMP:     temp_c   <= wb_dat_i[15:0];
        `SDR_OFF_SETPOINT: setpoint <= wb_dat_i[15:0];
        `SDR_OFF_ANODE:    anode_v  <= wb_dat_i[15:0];
        `SDR_OFF_EMIS:     emis_mv  <= wb_dat_i[15:0];
        `SDR_OFF_RFFREQ:   rf_khz   <= wb_dat_i[15:0];
        `SDR_OFF_PORT1:    port1    <= wb_dat_i;
        `SDR_OFF_PORT2:    port2    <= wb_dat_i;
        default: ;
      endcase
    end
  end

  // ---------------- derived readings and range checks
  wire [15:0] anode_rb  = 16'(anode_v / `SDR_ANODE_DIV); // R15
  wire [15:0] setpt_rb  = {1'b0, setpoint[15:1]}; // R16
  wire        anode_lo  = anode_rb < `SDR_ANODE_MIN; // R8
  wire        anode_hi  = anode_rb > `SDR_ANODE_MAX; // R8
  wire        integ_lo  = emis_mv < `SDR_EMIS_MIN_MV; // R13
  wire        integ_hi  = emis_mv > `SDR_EMIS_MAX_MV; // R13
  wire        over_temp = temp_c > `SDR_TEMP_MAX_C; // R14

  // ---------------- sticky anomaly bytes and warning counters
  sdr_anom_t anom;
  sdr_evt_t  evt;
  logic      anode_bad_q;
  logic [CNT_W-1:0] warn_cnt [4];
  assign evt.mult    = evt_w[`SDR_EVT_MULT];
  assign evt.emis    = evt_w[`SDR_EVT_EMIS] || evt_w[`SDR_EVT_COLD] || evt_w[`SDR_EVT_WARM];
  assign evt.rf_freq = evt_w[`SDR_EVT_RFFREQ];
  assign evt.rf_amp  = evt_w[`SDR_EVT_RFAMP];
  // counting only the step out of range keeps a slow readback from inflating the count
  wire anode_new = (anode_lo || anode_hi) && !anode_bad_q && anode_v != 16'h0000;
  wire [3:0] warn_hit = {evt.rf_freq || evt.rf_amp, evt.emis, evt.mult, anode_new}; // R8
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      anom        <= '0;
      anode_bad_q <= 1'b0;
    end else begin
      anode_bad_q <= (anode_lo || anode_hi) && anode_v != 16'h0000;
      anom.anode[7] <= anom.anode[7] || (anode_new && anode_lo); // R10 R20
      anom.anode[6] <= anom.anode[6] || (anode_new && anode_hi); // R10 R20
      anom.cc[5:1]  <= anom.cc[5:1] | evt_w[`SDR_EVT_CC_LSB+1 +: 5]; // R11 R20
      anom.tune[7:4] <= anom.tune[7:4] | evt_w[`SDR_EVT_TUNE_LSB+4 +: 4]; // R12 R20
      anom.emis[7]  <= anom.emis[7] || (evt.emis && integ_lo); // R13 R20
      anom.emis[6]  <= anom.emis[6] || (evt.emis && integ_hi); // R13 R20
      anom.emis[5]  <= anom.emis[5] || evt_w[`SDR_EVT_COLD]; // R13 R20
      anom.emis[4]  <= anom.emis[4] || evt_w[`SDR_EVT_WARM]; // R13 R20
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_warn
      // saturates rather than wraps so a long run never reads as healthy
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) warn_cnt[gi] <= '0; // R7
        else if (warn_hit[gi] && warn_cnt[gi] != '1) warn_cnt[gi] <= warn_cnt[gi] + 1'b1; // R7
      end
    end
  endgenerate

  // ---------------- own port statistics
  logic [15:0] p0_rx;
  logic [7:0]  p0_err;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_rx  <= 16'h0000;
      p0_err <= 8'h00;
    end else begin
      if (rx_done && p0_rx != 16'hFFFF) p0_rx <= p0_rx + 16'd1; // R18
      if (rx_ferr && p0_err != 8'hFF) p0_err <= p0_err + 8'd1; // R18
    end
  end

  // ---------------- report item table
  logic [4:0] item;
  logic [3:0] chr;
  wire [31:0] item_val =
    (item == 5'd0)  ? 32'(warn_cnt[0]) : (item == 5'd1)  ? 32'(warn_cnt[1]) : // R7
    (item == 5'd2)  ? 32'(warn_cnt[2]) : (item == 5'd3)  ? 32'(warn_cnt[3]) :
    (item == 5'd4)  ? {24'h0, anom.anode} : (item == 5'd5) ? {24'h0, anom.cc} : // R9
    (item == 5'd6)  ? {24'h0, anom.tune}  : (item == 5'd7) ? {24'h0, anom.emis} :
    (item == 5'd8)  ? {15'h0, over_temp, temp_c} : (item == 5'd9) ? {16'h0, setpt_rb} : // R14
    (item == 5'd10) ? {16'h0, anode_rb} : (item == 5'd11) ? {16'h0, emis_mv} :
    (item == 5'd12) ? {16'h0, rf_khz} : // R17
    (item == 5'd13) ? {14'h0, remote_inputs, 8'h00, config_switches} : // R18
    (item == 5'd14) ? {p0_rx, p0_err, 8'h00} : (item == 5'd15) ? port1 : port2; // R18
  wire [7:0] item_tag = 8'(8'h41 + {3'b000, item});
  wire [3:0] nib = 4'(item_val >> (5'd28 - 5'(({1'b0, chr} - 5'd2) << 2)));
  wire [7:0] hex = (nib < 4'hA) ? 8'(8'h30 + {4'h0, nib}) : 8'(8'h37 + {4'h0, nib});
  wire [7:0] rep_char = (chr == 4'd0)  ? item_tag : (chr == 4'd1) ? `SDR_CHAR_EQ :
                        (chr == 4'd10) ? `SDR_CHAR_CR : // R19
                        (chr == 4'd11) ? `SDR_CHAR_LF : hex; // R19

  // ---------------- report sequencer and transmitter
  sdr_rep_t    rep;
  logic        tx_busy;
  logic [15:0] tx_cnt;
  logic [3:0]  tx_bit;
  logic [9:0]  tx_sh;
  wire tx_load = rep == SDR_SEND && !tx_busy;
  wire tx_tick = tx_busy && tx_cnt == 16'd0;
  wire last_chr = chr == `SDR_LINE_CHARS - 4'd1;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rep  <= SDR_IDLE;
      item <= 5'd0;
      chr  <= 4'd0;
    end else begin
      case (rep)
        SDR_IDLE: if (query && diag_en) begin // R5
          rep  <= SDR_SEND;
          item <= 5'd0;
          chr  <= 4'd0;
        end
        SDR_SEND: if (tx_load) begin
          chr <= last_chr ? 4'd0 : chr + 4'd1;
          if (last_chr) item <= item + 5'd1;
          if (last_chr && item == `SDR_ITEMS - 5'd1) rep <= SDR_WAIT; // R5
        end
        SDR_WAIT: if (!tx_busy) rep <= SDR_IDLE;
        default: rep <= SDR_IDLE;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      tx_cnt  <= 16'd0;
      tx_bit  <= 4'd0;
      tx_sh   <= 10'h3FF;
      diag_tx <= 1'b1;
    end else begin
      if (tx_load) begin
        tx_busy <= 1'b1;
        tx_sh   <= {1'b1, rep_char, 1'b0}; // R4
        tx_cnt  <= bit_cyc - 16'd1;
        tx_bit  <= 4'd0;
      end else if (tx_tick) begin
        tx_sh  <= {1'b1, tx_sh[9:1]};
        tx_cnt <= bit_cyc - 16'd1;
        tx_bit <= tx_bit + 4'd1;
        if (tx_bit == 4'd9) tx_busy <= 1'b0;
      end else if (tx_busy) begin
        tx_cnt <= tx_cnt - 16'd1;
      end
      diag_tx <= tx_load ? 1'b0 : (tx_tick && tx_bit != 4'd9) ? tx_sh[1] : diag_tx;
    end
  end

  // ---------------- wishbone read side
  wire [31:0] rd_mux =
    (wb_adr_i == `SDR_OFF_STATUS)  ? {27'h0, over_temp, rep != SDR_IDLE, baud_sel, diag_en} :
    (wb_adr_i == `SDR_OFF_TEMP)    ? {16'h0, temp_c}   :
    (wb_adr_i == `SDR_OFF_SETPOINT)? {16'h0, setpoint} :
    (wb_adr_i == `SDR_OFF_ANODE)   ? {16'h0, anode_v}  :
    (wb_adr_i == `SDR_OFF_EMIS)    ? {16'h0, emis_mv}  :
    (wb_adr_i == `SDR_OFF_RFFREQ)  ? {16'h0, rf_khz}   :
    (wb_adr_i == `SDR_OFF_PORT1)   ? port1 : (wb_adr_i == `SDR_OFF_PORT2) ? port2 :
    (wb_adr_i == `SDR_OFF_ANOMALY) ? anom : // R9
    (wb_adr_i == `SDR_OFF_CNT_LO)  ? {16'(warn_cnt[1]), 16'(warn_cnt[0])} :
    (wb_adr_i == `SDR_OFF_CNT_HI)  ? {16'(warn_cnt[3]), 16'(warn_cnt[2])} :
    (wb_adr_i == `SDR_OFF_PORT0)   ? {p0_rx, p0_err, 8'h00} : 32'h0000_0000;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
      diag_active <= 1'b0;
    end else begin
      wb_ack_o    <= wb_req;
      wb_dat_o    <= (wb_req && !wb_we_i) ? rd_mux : 32'h0000_0000;
      diag_active <= diag_en;
    end
  end

  // ---------------- checks
  anode_reserved_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
    anom.anode[5:0] == 6'h00) else $error("anode reserved bits set");
  cc_reserved_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
    anom.cc[7:6] == 2'b00 && !anom.cc[0]) else $error("control card reserved bits set");
  tune_emis_resv_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
    anom.tune[3:0] == 4'h0 && anom.emis[3:0] == 4'h0) else $error("low reserved bits set");
  anom_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R20
    ($past(anom) & ~anom) == 32'h0) else $error("anomaly bit cleared");
  baud_frozen_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
    $past(baud_taken) |-> $stable(baud_sel)) else $error("baud select changed");
  query_start_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
    rep == SDR_IDLE && query && diag_en |=> rep == SDR_SEND ##1 !diag_tx)
    else $error("report not started");
  counter_step_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
    warn_hit[1] && warn_cnt[1] != '1 |=> warn_cnt[1] == $past(warn_cnt[1]) + 1'b1)
    else $error("multiplier count missed");
  line_end_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R19
    tx_load && chr == 4'd10 |-> rep_char == `SDR_CHAR_CR) else $error("line lacks cr");
  stop_bit_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
    tx_busy && tx_bit == 4'd9 |-> diag_tx) else $error("stop bit low");
  role_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
    link_role_switch |=> !diag_active) else $error("diagnostic link active in primary role");
  ack_once_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  report_c: cover property (@(posedge core_clk) disable iff (!rst_n) rep == SDR_WAIT);
  anode_low_c: cover property (@(posedge core_clk) disable iff (!rst_n) anom.anode[7]);
  frame_err_c: cover property (@(posedge core_clk) disable iff (!rst_n) rx_ferr);
endmodule // sdr_top

// *** shared/sdr_map.svh ***
// constants of the serial diagnostic status reporter: offsets, fields, resets, timing
// assumes a 200 MHz core clock and 32-bit classic wishbone byte addressing
`ifndef SDR_MAP_SVH
`define SDR_MAP_SVH
`define SDR_CLK_HZ        200000000
`define SDR_BAUD_00       9600
`define SDR_BAUD_01       19200
`define SDR_BAUD_10       38400
`define SDR_BAUD_11       4800
`define SDR_OFF_STATUS    8'h00
`define SDR_OFF_EVENT     8'h04
`define SDR_OFF_TEMP      8'h08
`define SDR_OFF_SETPOINT  8'h0C
`define SDR_OFF_ANODE     8'h10
`define SDR_OFF_EMIS      8'h14
`define SDR_OFF_RFFREQ    8'h18
`define SDR_OFF_PORT1     8'h1C
`define SDR_OFF_PORT2     8'h20
`define SDR_OFF_ANOMALY   8'h24
`define SDR_OFF_CNT_LO    8'h28
`define SDR_OFF_CNT_HI    8'h2C
`define SDR_OFF_PORT0     8'h30
`define SDR_EVT_MULT      0
`define SDR_EVT_EMIS      1
`define SDR_EVT_RFFREQ    2
`define SDR_EVT_RFAMP     3
`define SDR_EVT_CC_LSB    8
`define SDR_EVT_TUNE_LSB  16
`define SDR_EVT_COLD      24
`define SDR_EVT_WARM      25
`define SDR_ANODE_DIV     16'd100
`define SDR_ANODE_MIN     16'd202
`define SDR_ANODE_MAX     16'd220
`define SDR_EMIS_MIN_MV   16'd500
`define SDR_EMIS_MAX_MV   16'd3000
`define SDR_TEMP_MAX_C    16'd75
`define SDR_QUERY_CHAR    8'h3F
`define SDR_CHAR_CR       8'h0D
`define SDR_CHAR_LF       8'h0A
`define SDR_CHAR_EQ       8'h3D
`define SDR_LINE_CHARS    4'd12
`define SDR_ITEMS         5'd17
`define SDR_RESET_WORD    32'h0000_0000
`endif

// *** shared/sdr_pkg.sv ***
// types of the serial diagnostic status reporter
// assumes sdr_map.svh holds every number
package sdr_pkg;
  typedef struct packed {
    logic mult;
    logic emis;
    logic rf_freq;
    logic rf_amp;
  } sdr_evt_t;
  typedef struct packed {
    logic [7:0] emis;
    logic [7:0] tune;
    logic [7:0] cc;
    logic [7:0] anode;
  } sdr_anom_t;
  typedef enum logic [1:0] {SDR_IDLE, SDR_SEND, SDR_WAIT} sdr_rep_t;
endpackage

// *** sim/sdr_terminal.sv ***
// terminal model on the far side of the diagnostic serial link
// assumes the bench sets bit_cyc to the rate picked by the baud switches
module sdr_terminal #(
  parameter int BIT_CYC = 16
) (
  input  wire logic core_clk,
  input  wire logic diag_tx,
  output logic      diag_rx
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rxq [$];
  logic [7:0] shift_byte;
  int         bad_stop = 0;
  int         bit_cyc = BIT_CYC;
  // line idles at mark level between frames
  initial diag_rx = 1'b1;
  // start low, 8 data lsb first, no parity, one stop, same rate as device;
  // a low stop bit makes a framing error, then the line returns to mark
  task automatic send_char(input logic [7:0] c, input logic stop = 1'b1);
    logic [9:0] frame;
    frame = {stop, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      diag_rx <= frame[i];
      repeat (bit_cyc - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    diag_rx <= 1'b1;
  endtask
  // sample mid-bit; stop must be high or the frame is counted bad
  always begin
    @(negedge diag_tx);
    repeat (bit_cyc / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge core_clk);
      shift_byte[i] = diag_tx;
    end
    repeat (bit_cyc) @(posedge core_clk);
    if (diag_tx !== 1'b1) bad_stop++;
    rxq.push_back(shift_byte);
  end
endmodule // sdr_terminal

// *** sim/serial_diagnostic_status_reporter_bench.sv ***
// bench for the diagnostic reporter: wishbone accesses and one full text report
// assumes the terminal model of sdr_terminal.sv on the serial pins
`include "sdr_map.svh"
module serial_diagnostic_status_reporter_bench
  import sdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ANODE_SEQ [4] = '{32'h4E20, 32'h5208, 32'h57E4, 32'h5208};
  localparam logic [31:0] EVT_SEQ [8] = '{32'h1, 32'h4, 32'h8, 32'h3E00, 32'h00F0_0000,
    32'h0100_0000, 32'h0200_0000, 32'hFC0F_C1F0};
  localparam logic [31:0] EXP [17] = '{32'h2, 32'h1, 32'h5, 32'h2, 32'hC0, 32'h3E, 32'hF0,
    32'hF0, 32'h0001_004C, 32'h91A, 32'hD2, 32'hDAC, 32'h7D0, 32'h0002_006F, 32'h0003_0000,
    32'h0102_0304, 32'hA0B0_C0D0};
  logic        core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, config_switches;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        link_role_switch, baud_select_low_switch, baud_select_high_switch;
  logic [1:0]  remote_inputs;
  logic        diag_rx, diag_tx, diag_active;
  logic [95:0] line;
  int          errors, total_checks, cycles;
  sdr_top #(.BIT_CYC_00(16), .BIT_CYC_01(24), .BIT_CYC_10(32), .BIT_CYC_11(40))
    u_dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .link_role_switch(link_role_switch), .baud_select_low_switch(baud_select_low_switch),
    .baud_select_high_switch(baud_select_high_switch), .config_switches(config_switches),
    .remote_inputs(remote_inputs), .diag_rx(diag_rx), .diag_tx(diag_tx),
    .diag_active(diag_active));
  sdr_terminal u_term (.core_clk(core_clk), .diag_tx(diag_tx), .diag_rx(diag_rx));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // classic cycle: hold until ack is sampled, then release for a cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel = 4'hF);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    // only the bench watchdog ends a wait for ack
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic rdchk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    check(name, {64'h0, rd}, {64'h0, exp});
  endtask
  task automatic wait_chars(input int n, input int lim);
    int k;
    k = 0;
    while (u_term.rxq.size() < n && k < lim) begin
      @(posedge core_clk);
      k++;
    end
  endtask
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  // tag letter, '=', eight hex digits, cr lf
  function automatic logic [95:0] mk(input int idx, input logic [31:0] v);
    logic [95:0] l;
    l = {8'h41 + 8'(idx), 8'h3D, 64'h0, 8'h0D, 8'h0A};
    for (int j = 0; j < 8; j++) l[79 - 8 * j -: 8] = hx(v[31 - 4 * j -: 4]);
    return l;
  endfunction
  // hang guard, well above one report at the sim bit rate
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    rst_n = 1'b0; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
    wb_adr_i = 8'h00; wb_sel_i = 4'hF; wb_dat_i = 32'h0; link_role_switch = 1'b0;
    baud_select_low_switch = 1'b0; baud_select_high_switch = 1'b0;
    config_switches = 8'h6F; remote_inputs = 2'b10;
    errors = 0; total_checks = 0; cycles = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    // late switch change must not alter the rate until the next reset
    baud_select_low_switch <= 1'b1;
    baud_select_high_switch <= 1'b1;
    rdchk("status", `SDR_OFF_STATUS, 32'h1);
    wb(1'b1, `SDR_OFF_TEMP, 32'h4B);
    rdchk("status", `SDR_OFF_STATUS, 32'h1);
    wb(1'b1, `SDR_OFF_TEMP, 32'h4C);
    rdchk("status", `SDR_OFF_STATUS, 32'h11);
    foreach (ANODE_SEQ[i]) wb(1'b1, `SDR_OFF_ANODE, ANODE_SEQ[i]);
    wb(1'b1, `SDR_OFF_EMIS, 32'h190);
    wb(1'b1, `SDR_OFF_EVENT, 32'h2);
    wb(1'b1, `SDR_OFF_EMIS, 32'hDAC);
    wb(1'b1, `SDR_OFF_EVENT, 32'h2);
    foreach (EVT_SEQ[i]) wb(1'b1, `SDR_OFF_EVENT, EVT_SEQ[i]);
    // byte lanes: only the top byte lands, so one emission count and nothing else
    wb(1'b1, `SDR_OFF_EVENT, 32'h0300_000F, 4'h8);
    wb(1'b1, `SDR_OFF_ANOMALY, 32'hFFFF_FFFF);
    rdchk("anomaly", `SDR_OFF_ANOMALY, 32'hF0F0_3EC0);
    rdchk("counts low", `SDR_OFF_CNT_LO, 32'h0001_0002);
    rdchk("counts high", `SDR_OFF_CNT_HI, 32'h0002_0005);
    wb(1'b1, `SDR_OFF_SETPOINT, 32'h1234);
    wb(1'b1, `SDR_OFF_RFFREQ, 32'h7D0);
    wb(1'b1, `SDR_OFF_PORT1, 32'h0102_0304);
    wb(1'b1, `SDR_OFF_PORT2, 32'hA0B0_C0D0);
    wb(1'b1, 8'hFC, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'hFC, 32'h0);
    link_role_switch <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("active", {95'h0, diag_active}, 96'h0);
    u_term.send_char(`SDR_QUERY_CHAR);
    repeat (400) @(posedge core_clk);
    check("chars", 96'(u_term.rxq.size()), 96'h0);
    link_role_switch <= 1'b0;
    repeat (3) @(posedge core_clk);
    check("active", {95'h0, diag_active}, 96'h1);
    u_term.send_char(8'h41);
    repeat (400) @(posedge core_clk);
    check("chars", 96'(u_term.rxq.size()), 96'h0);
    u_term.send_char(`SDR_QUERY_CHAR);
    wait_chars(3, 2000);
    rdchk("status", `SDR_OFF_STATUS, 32'h19);
    // a second query mid-report is dropped
    u_term.send_char(`SDR_QUERY_CHAR);
    wait_chars(204, 40000);
    repeat (2000) @(posedge core_clk);
    check("chars", 96'(u_term.rxq.size()), 96'd204);
    for (int i = 0; i < 17 && u_term.rxq.size() == 204; i++) begin
      for (int j = 0; j < 12; j++) line = {line[87:0], u_term.rxq[12 * i + j]};
      check("report line", line, mk(i, EXP[i]));
    end
    // each reset takes the switches anew and clears counts and anomalies
    for (int m = 1; m < 4; m++) begin
      rst_n <= 1'b0;
      baud_select_low_switch  <= m[0];
      baud_select_high_switch <= m[1];
      u_term.bit_cyc = 16 + 8 * m;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      rdchk("status", `SDR_OFF_STATUS, 32'(2 * m + 1));
      rdchk("counts high", `SDR_OFF_CNT_HI, 32'h0);
      rdchk("anomaly", `SDR_OFF_ANOMALY, 32'h0);
      // a query whose stop bit is low is a framing error, not a request
      u_term.send_char(8'h41, 1'b1);
      u_term.send_char(`SDR_QUERY_CHAR, 1'b0);
      rdchk("port0", `SDR_OFF_PORT0, 32'h0001_0100);
      rdchk("status", `SDR_OFF_STATUS, 32'(2 * m + 1));
    end
    check("bad stop", 96'(u_term.bad_stop), 96'h0);
    complete_run();
  end
endmodule // serial_diagnostic_status_reporter_bench
